// [bsu_top.sv]
`timescale 1ns/1ps
module bsu_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              REF_CLK,
    input  wire logic              RST_N,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    output logic                   BUSY
);
    import bsu_pkg::*;

    bsu_state_t             state_ff;
    bsu_op_t                op_ff;
    logic [7:0]             rd_ff;
    logic [7:0]             rr_ff;
    logic [2:0]             bit_ff;
    logic                   long_ff;
    logic [PC_W-1:0]        pc_ff;
    logic [PC_W-1:0]        zptr_ff;
    logic [PC_W-1:0]        stack_ff;
    logic [7:0]             flags_ff;
    logic [OFF_W-1:0]       offset_ff;
    logic [7:0]             io_ff;
    logic [7:0]             result_ff;
    logic [2:0]             cnt_ff;
    logic [2:0]             last_cyc_ff;
    logic                   illegal_ff;
    logic                   pready_ff;
    logic                   pslverr_ff;
    logic [31:0]            prdata_ff;
    logic                   busy_ff;

    bsu_alu_t               alu;
    logic                   apb_done;
    logic                   mapped;
    logic                   wr_ok;
    logic                   refuse;
    logic                   start;
    logic                   commit;
    logic [31:0]            rd_mux;
    logic [PC_W-1:0]        k_ext;
    logic [PC_W-1:0]        pc_rel;
    logic [PC_W-1:0]        pc_step;
    logic [PC_W-1:0]        skip_step;
    logic [2:0]             skip_cyc;
    logic                   is_skip;
    logic                   is_branch;
    logic                   cond;
    logic                   known_op;
    logic [PC_W-1:0]        nxt_pc;
    logic [PC_W-1:0]        nxt_stack;
    logic [7:0]             nxt_flags;
    logic [7:0]             nxt_io;
    logic [2:0]             need_cyc;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a == ADDR_W'(off));
    endfunction

    // polarity and source bit of every skip and branch in one place
    function automatic logic test_cond(input bsu_op_t op, input logic [7:0] f,
                                       input logic [7:0] rd, input logic [7:0] rr,
                                       input logic [7:0] io, input logic [2:0] b);
        case (op)
            OP_COMPARE_SKIP_EQUAL:       test_cond = (rd == rr);
            OP_SKIP_REG_BIT_ZERO:        test_cond = ~rr[b];
            OP_SKIP_REG_BIT_ONE:         test_cond = rr[b];
            OP_SKIP_IO_BIT_ZERO:         test_cond = ~io[b];
            OP_SKIP_IO_BIT_ONE:          test_cond = io[b];
            OP_BRANCH_FLAG_ONE:          test_cond = f[b];
            OP_BRANCH_FLAG_ZERO:         test_cond = ~f[b];
            OP_BRANCH_EQUAL:             test_cond = f[FLAG_Z];
            OP_BRANCH_NOT_EQUAL:         test_cond = ~f[FLAG_Z];
            OP_BRANCH_CARRY_ONE:         test_cond = f[FLAG_C];
            OP_BRANCH_LOWER:             test_cond = f[FLAG_C];
            OP_BRANCH_CARRY_ZERO:        test_cond = ~f[FLAG_C];
            OP_BRANCH_SAME_OR_HIGHER:    test_cond = ~f[FLAG_C];
            OP_BRANCH_NEGATIVE:          test_cond = f[FLAG_N];
            OP_BRANCH_POSITIVE:          test_cond = ~f[FLAG_N];
            OP_BRANCH_SIGNED_GE:         test_cond = ~(f[FLAG_N] ^ f[FLAG_V]);
            OP_BRANCH_SIGNED_LESS:       test_cond = f[FLAG_N] ^ f[FLAG_V];
            OP_BRANCH_HALF_CARRY_ONE:    test_cond = f[FLAG_H];
            OP_BRANCH_HALF_CARRY_ZERO:   test_cond = ~f[FLAG_H];
            OP_BRANCH_TRANSFER_BIT_ONE:  test_cond = f[FLAG_T];
            OP_BRANCH_TRANSFER_BIT_ZERO: test_cond = ~f[FLAG_T];
            OP_BRANCH_OVERFLOW_ONE:      test_cond = f[FLAG_V];
            OP_BRANCH_OVERFLOW_ZERO:     test_cond = ~f[FLAG_V];
            OP_BRANCH_INTERRUPTS_ON:     test_cond = f[FLAG_I];
            OP_BRANCH_INTERRUPTS_OFF:    test_cond = ~f[FLAG_I];
            default:                     test_cond = 1'b0;
        endcase
    endfunction

    bsu_alu u_alu (
        .op    (op_ff),
        .rd    (rd_ff),
        .rr    ((op_ff == OP_COMPARE_IMMEDIATE) ? rr_ff : rr_ff),
        .flags (flags_ff),
        .res   (alu)
    );

    // apb: answer lands one cycle into the access phase
    assign apb_done = PSEL & PENABLE & pready_ff;
    assign mapped   = hit(PADDR, ADDR_CTRL) | hit(PADDR, ADDR_OPND) | hit(PADDR, ADDR_PC)
                    | hit(PADDR, ADDR_ZPTR) | hit(PADDR, ADDR_STACK) | hit(PADDR, ADDR_FLAGS)
                    | hit(PADDR, ADDR_OFFSET) | hit(PADDR, ADDR_IO)
                    | hit(PADDR, ADDR_RESULT) | hit(PADDR, ADDR_STATUS);
    // writes during execution would tear the operands, so they are refused
    assign refuse   = ~mapped | (PWRITE & busy_ff);
    // registered verdict: busy may fall between the error decision and the ready edge
    assign wr_ok    = apb_done & PWRITE & ~pslverr_ff;
    assign start    = wr_ok & hit(PADDR, ADDR_CTRL) & PWDATA[CTRL_START_BIT];
    assign commit   = (state_ff == ST_RUN) & (cnt_ff == need_cyc);

    assign rd_mux =
        hit(PADDR, ADDR_CTRL)   ? {18'h00000, 6'(op_ff), 8'h00} :
        hit(PADDR, ADDR_OPND)   ? {12'h000, long_ff, bit_ff, rr_ff, rd_ff} :
        hit(PADDR, ADDR_PC)     ? {16'h0000, pc_ff} :
        hit(PADDR, ADDR_ZPTR)   ? {16'h0000, zptr_ff} :
        hit(PADDR, ADDR_STACK)  ? {16'h0000, stack_ff} :
        hit(PADDR, ADDR_FLAGS)  ? {24'h000000, flags_ff} :
        hit(PADDR, ADDR_OFFSET) ? {20'h00000, offset_ff} :
        hit(PADDR, ADDR_IO)     ? {24'h000000, io_ff} :
        hit(PADDR, ADDR_RESULT) ? {24'h000000, result_ff} :
        hit(PADDR, ADDR_STATUS) ? {25'h0000000, last_cyc_ff, 2'h0, illegal_ff, busy_ff} :
                                  32'h00000000;

    // sign extension lets targets lie behind the current word
    assign k_ext     = {{(PC_W-OFF_W){offset_ff[OFF_W-1]}}, offset_ff};
    assign pc_step   = pc_ff + STEP_ONE;
    assign pc_rel    = pc_ff + k_ext + STEP_ONE;
    assign skip_step = long_ff ? STEP_SKIP_LONG : STEP_SKIP_SHORT;
    assign skip_cyc  = long_ff ? CYC_SKIP_LONG : CYC_SKIP_SHORT;
    assign is_skip   = (op_ff == OP_COMPARE_SKIP_EQUAL) || (op_ff == OP_SKIP_REG_BIT_ZERO)
                    || (op_ff == OP_SKIP_REG_BIT_ONE) || (op_ff == OP_SKIP_IO_BIT_ZERO)
                    || (op_ff == OP_SKIP_IO_BIT_ONE);
    assign is_branch = (op_ff >= OP_BRANCH_FLAG_ONE) && (op_ff <= OP_BRANCH_INTERRUPTS_OFF);
    assign known_op  = (op_ff <= OP_ROTATE_LEFT_CARRY);
    assign cond      = test_cond(op_ff, flags_ff, rd_ff, rr_ff, io_ff, bit_ff);

    always_comb begin
        nxt_pc    = pc_step;
        nxt_stack = stack_ff;
        nxt_flags = flags_ff;
        nxt_io    = io_ff;
        need_cyc  = CYC_SINGLE;
        case (op_ff)
            OP_ZERO_REGISTER, OP_COMPARE_REGS, OP_COMPARE_WITH_BORROW, OP_COMPARE_IMMEDIATE,
            OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY: begin
                nxt_flags = alu.flags;
            end
            OP_RELATIVE_JUMP: begin
                nxt_pc   = pc_rel;
                need_cyc = CYC_JUMP;
            end
            OP_POINTER_JUMP: begin
                nxt_pc   = zptr_ff;
                need_cyc = CYC_JUMP;
            end
            OP_RELATIVE_CALL: begin
                nxt_stack = pc_step;
                nxt_pc    = pc_rel;
                need_cyc  = CYC_CALL;
            end
            OP_POINTER_CALL: begin
                nxt_stack = pc_step;
                nxt_pc    = zptr_ff;
                need_cyc  = CYC_CALL;
            end
            OP_SUBROUTINE_EXIT: begin
                nxt_pc   = stack_ff;
                need_cyc = CYC_RETURN;
            end
            OP_INTERRUPT_EXIT: begin
                nxt_pc           = stack_ff;
                nxt_flags[FLAG_I] = 1'b1;
                need_cyc         = CYC_RETURN;
            end
            OP_IO_BIT_FORCE_ONE: begin
                nxt_io[bit_ff] = 1'b1;
                need_cyc       = CYC_IO_BIT;
            end
            OP_IO_BIT_FORCE_ZERO: begin
                nxt_io[bit_ff] = 1'b0;
                need_cyc       = CYC_IO_BIT;
            end
            default: begin
                if (is_skip && cond) begin
                    nxt_pc   = pc_ff + skip_step;
                    need_cyc = skip_cyc;
                end else if (is_branch && cond) begin
                    nxt_pc   = pc_rel;
                    need_cyc = CYC_TAKEN;
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end else begin
            pready_ff  <= PSEL & PENABLE & ~pready_ff;
            pslverr_ff <= PSEL & PENABLE & ~pready_ff & refuse;
            prdata_ff  <= (PSEL & PENABLE & ~pready_ff & ~PWRITE) ? rd_mux : 32'h00000000;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_ff    <= ST_IDLE;
            cnt_ff      <= CYC_SINGLE;
            busy_ff     <= 1'b0;
            last_cyc_ff <= 3'h0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (start) begin
                        state_ff <= ST_RUN;
                        busy_ff  <= 1'b1;
                    end
                    cnt_ff <= CYC_SINGLE;
                end
                ST_RUN: begin
                    if (commit) begin
                        state_ff    <= ST_IDLE;
                        busy_ff     <= 1'b0;
                        last_cyc_ff <= need_cyc;
                        cnt_ff      <= CYC_SINGLE;
                    end else begin
                        cnt_ff <= cnt_ff + 3'h1;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    busy_ff  <= 1'b0;
                end
            endcase
        end
    end

    // software writes only while idle, the engine writes only on commit
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            op_ff <= RST_OP;
            rd_ff <= RST_BYTE;
            rr_ff <= RST_BYTE;
            bit_ff <= 3'h0;
            long_ff <= 1'b0;
            zptr_ff <= RST_PC;
            offset_ff <= 12'h000;
        end else if (wr_ok) begin
            if (hit(PADDR, ADDR_CTRL)) begin
                op_ff <= bsu_op_t'(PWDATA[CTRL_OP_LSB +: 6]);
            end
            if (hit(PADDR, ADDR_OPND)) begin
                rd_ff   <= PWDATA[OPND_RD_LSB +: 8];
                rr_ff   <= PWDATA[OPND_RR_LSB +: 8];
                bit_ff  <= PWDATA[OPND_BIT_LSB +: 3];
                long_ff <= PWDATA[OPND_LONG_BIT];
            end
            if (hit(PADDR, ADDR_ZPTR)) begin
                zptr_ff <= PWDATA[PC_W-1:0];
            end
            if (hit(PADDR, ADDR_OFFSET)) begin
                offset_ff <= PWDATA[OFF_W-1:0];
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pc_ff      <= RST_PC;
            stack_ff   <= RST_PC;
            flags_ff   <= RST_BYTE;
            io_ff      <= RST_BYTE;
            result_ff  <= RST_BYTE;
            illegal_ff <= 1'b0;
        end else if (commit) begin
            pc_ff      <= nxt_pc;
            stack_ff   <= nxt_stack;
            flags_ff   <= nxt_flags;
            io_ff      <= nxt_io;
            illegal_ff <= ~known_op;
            if (alu.writes_rd) begin
                result_ff <= alu.result;
            end
        end else if (wr_ok) begin
            if (hit(PADDR, ADDR_PC)) begin
                pc_ff <= PWDATA[PC_W-1:0];
            end
            if (hit(PADDR, ADDR_STACK)) begin
                stack_ff <= PWDATA[PC_W-1:0];
            end
            if (hit(PADDR, ADDR_FLAGS)) begin
                flags_ff <= PWDATA[7:0];
            end
            if (hit(PADDR, ADDR_IO)) begin
                io_ff <= PWDATA[7:0];
            end
        end
    end

    assign PRDATA  = prdata_ff;
    assign PREADY  = pready_ff;
    assign PSLVERR = pslverr_ff;
    assign BUSY    = busy_ff;

endmodule

// [bsu_pkg.sv]
// What this block does
// - zero_register writes zero, updates Z N V; all_ones_register loads FF, 1 cycle
// - relative_jump goes to PC+k+1, pointer_jump to Z; 2 cycles, no flags
// - calls target PC+k+1 or Z in 3 cycles; both exits reload PC in 4
// - interrupt_exit also sets I; subroutine_exit leaves every flag alone
// - compare_skip_equal skips when equal: PC+2 or +3, 1/2/3 cycles, no flags
// - compares subtract without storing, update Z N V C H, 1 cycle
// - skip_reg_bit_zero skips when the chosen register bit is 0
// - skip_reg_bit_one skips when the chosen register bit is 1
// - skip_io_bit_zero skips when the chosen I/O bit is 0
// - skip_io_bit_one skips when the chosen I/O bit is 1
// - branch_flag_one branches on a set status bit, 1 or 2 cycles
// - branch_flag_zero branches on a clear status bit, 1 or 2 cycles
// - equal/not-equal on Z, carry/lower/higher on C, negative/positive on N
// - branch_signed_ge taken when N xor V is 0
// - branch_signed_less taken when N xor V is 1
// - half-carry branches test H, transfer-bit branches test T
// - overflow branches test V set or clear
// - interrupt-state branches test I, change no flags
// - io_bit_force_one and io_bit_force_zero touch only one bit, 2 cycles
// - shift_left_logical moves bits up, zero into bit 0, Z C N V
// - shift_right_logical moves bits down, zero into bit 7, Z C N V
// - rotate_left_carry feeds carry into bit 0, old bit 7 to carry
package bsu_pkg;

    localparam int PC_W  = 16;
    localparam int OFF_W = 12;

    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_OPND   = 8'h04;
    localparam logic [7:0] ADDR_PC     = 8'h08;
    localparam logic [7:0] ADDR_ZPTR   = 8'h0C;
    localparam logic [7:0] ADDR_STACK  = 8'h10;
    localparam logic [7:0] ADDR_FLAGS  = 8'h14;
    localparam logic [7:0] ADDR_OFFSET = 8'h18;
    localparam logic [7:0] ADDR_IO     = 8'h1C;
    localparam logic [7:0] ADDR_RESULT = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;

    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_OP_LSB    = 8;
    localparam int OPND_RD_LSB    = 0;
    localparam int OPND_RR_LSB    = 8;
    localparam int OPND_BIT_LSB   = 16;
    localparam int OPND_LONG_BIT  = 19;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_ILL_BIT   = 1;
    localparam int STAT_CYC_LSB   = 4;

    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    localparam logic [7:0]      RST_BYTE = 8'h00;
    localparam logic [PC_W-1:0] RST_PC   = 16'h0000;
    localparam logic [7:0]      ONES     = 8'hFF;

    localparam logic [2:0] CYC_SINGLE     = 3'h1;
    localparam logic [2:0] CYC_JUMP       = 3'h2;
    localparam logic [2:0] CYC_CALL       = 3'h3;
    localparam logic [2:0] CYC_RETURN     = 3'h4;
    localparam logic [2:0] CYC_IO_BIT     = 3'h2;
    localparam logic [2:0] CYC_TAKEN      = 3'h2;
    localparam logic [2:0] CYC_SKIP_SHORT = 3'h2;
    localparam logic [2:0] CYC_SKIP_LONG  = 3'h3;
    localparam logic [PC_W-1:0] STEP_ONE        = 16'h0001;
    localparam logic [PC_W-1:0] STEP_SKIP_SHORT = 16'h0002;
    localparam logic [PC_W-1:0] STEP_SKIP_LONG  = 16'h0003;

    typedef enum logic [5:0] {
        OP_ZERO_REGISTER           = 6'h00,
        OP_ALL_ONES_REGISTER       = 6'h01,
        OP_RELATIVE_JUMP           = 6'h02,
        OP_POINTER_JUMP            = 6'h03,
        OP_RELATIVE_CALL           = 6'h04,
        OP_POINTER_CALL            = 6'h05,
        OP_SUBROUTINE_EXIT         = 6'h06,
        OP_INTERRUPT_EXIT          = 6'h07,
        OP_COMPARE_SKIP_EQUAL      = 6'h08,
        OP_COMPARE_REGS            = 6'h09,
        OP_COMPARE_WITH_BORROW     = 6'h0A,
        OP_COMPARE_IMMEDIATE       = 6'h0B,
        OP_SKIP_REG_BIT_ZERO       = 6'h0C,
        OP_SKIP_REG_BIT_ONE        = 6'h0D,
        OP_SKIP_IO_BIT_ZERO        = 6'h0E,
        OP_SKIP_IO_BIT_ONE         = 6'h0F,
        OP_BRANCH_FLAG_ONE         = 6'h10,
        OP_BRANCH_FLAG_ZERO        = 6'h11,
        OP_BRANCH_EQUAL            = 6'h12,
        OP_BRANCH_NOT_EQUAL        = 6'h13,
        OP_BRANCH_CARRY_ONE        = 6'h14,
        OP_BRANCH_CARRY_ZERO       = 6'h15,
        OP_BRANCH_SAME_OR_HIGHER   = 6'h16,
        OP_BRANCH_LOWER            = 6'h17,
        OP_BRANCH_NEGATIVE         = 6'h18,
        OP_BRANCH_POSITIVE         = 6'h19,
        OP_BRANCH_SIGNED_GE        = 6'h1A,
        OP_BRANCH_SIGNED_LESS      = 6'h1B,
        OP_BRANCH_HALF_CARRY_ONE   = 6'h1C,
        OP_BRANCH_HALF_CARRY_ZERO  = 6'h1D,
        OP_BRANCH_TRANSFER_BIT_ONE = 6'h1E,
        OP_BRANCH_TRANSFER_BIT_ZERO = 6'h1F,
        OP_BRANCH_OVERFLOW_ONE     = 6'h20,
        OP_BRANCH_OVERFLOW_ZERO    = 6'h21,
        OP_BRANCH_INTERRUPTS_ON    = 6'h22,
        OP_BRANCH_INTERRUPTS_OFF   = 6'h23,
        OP_IO_BIT_FORCE_ONE        = 6'h24,
        OP_IO_BIT_FORCE_ZERO       = 6'h25,
        OP_SHIFT_LEFT_LOGICAL      = 6'h26,
        OP_SHIFT_RIGHT_LOGICAL     = 6'h27,
        OP_ROTATE_LEFT_CARRY       = 6'h28
    } bsu_op_t;

    localparam bsu_op_t RST_OP = OP_ZERO_REGISTER;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } bsu_state_t;

    typedef struct packed {
        logic [7:0] result;
        logic [7:0] flags;
        logic       writes_rd;
    } bsu_alu_t;

endpackage

// [bsu_alu.sv]
`timescale 1ns/1ps
module bsu_alu (
    input  wire bsu_pkg::bsu_op_t op,
    input  wire logic [7:0]       rd,
    input  wire logic [7:0]       rr,
    input  wire logic [7:0]       flags,
    output bsu_pkg::bsu_alu_t     res
);
    import bsu_pkg::*;

    logic [8:0] diff;
    logic [7:0] r;
    logic       borrow_in;
    logic       is_cmp;

    assign is_cmp    = (op == OP_COMPARE_REGS) || (op == OP_COMPARE_WITH_BORROW)
                       || (op == OP_COMPARE_IMMEDIATE);
    // carry only enters the compare-with-borrow form
    assign borrow_in = (op == OP_COMPARE_WITH_BORROW) ? flags[FLAG_C] : 1'b0;
    assign diff      = {1'b0, rd} - {1'b0, rr} - {8'h00, borrow_in};
    assign r         = diff[7:0];

    always_comb begin
        res           = '0;
        res.flags     = flags;
        res.writes_rd = 1'b0;
        case (op)
            OP_ZERO_REGISTER: begin
                res.result        = rd ^ rd;
                res.writes_rd     = 1'b1;
                res.flags[FLAG_Z] = 1'b1;
                res.flags[FLAG_N] = 1'b0;
                res.flags[FLAG_V] = 1'b0;
            end
            OP_ALL_ONES_REGISTER: begin
                res.result    = ONES;
                res.writes_rd = 1'b1;
            end
            OP_SHIFT_LEFT_LOGICAL: begin
                res.result        = {rd[6:0], 1'b0};
                res.writes_rd     = 1'b1;
                res.flags[FLAG_C] = rd[7];
                res.flags[FLAG_N] = rd[6];
                res.flags[FLAG_V] = rd[6] ^ rd[7];
                res.flags[FLAG_Z] = (rd[6:0] == 7'h00);
            end
            OP_SHIFT_RIGHT_LOGICAL: begin
                res.result        = {1'b0, rd[7:1]};
                res.writes_rd     = 1'b1;
                res.flags[FLAG_C] = rd[0];
                res.flags[FLAG_N] = 1'b0;
                res.flags[FLAG_V] = rd[0];
                res.flags[FLAG_Z] = (rd[7:1] == 7'h00);
            end
            OP_ROTATE_LEFT_CARRY: begin
                res.result        = {rd[6:0], flags[FLAG_C]};
                res.writes_rd     = 1'b1;
                res.flags[FLAG_C] = rd[7];
                res.flags[FLAG_N] = rd[6];
                res.flags[FLAG_V] = rd[6] ^ rd[7];
                res.flags[FLAG_Z] = ({rd[6:0], flags[FLAG_C]} == 8'h00);
            end
            default: begin
                if (is_cmp) begin
                    // difference is discarded, only the flags survive
                    res.flags[FLAG_Z] = (r == 8'h00);
                    res.flags[FLAG_N] = r[7];
                    res.flags[FLAG_C] = diff[8];
                    res.flags[FLAG_V] = (rd[7] & ~rr[7] & ~r[7]) | (~rd[7] & rr[7] & r[7]);
                    res.flags[FLAG_H] = (~rd[3] & rr[3]) | (rr[3] & r[3]) | (r[3] & ~rd[3]);
                end
            end
        endcase
    end
endmodule

// [bsu_chk.sv]
`timescale 1ns/1ps
module bsu_chk #(parameter int ADDR_W = 8) (
    input wire logic              REF_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, BUSY,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0]       PWDATA, PRDATA
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    wire logic [5:0] op = PWDATA[13:8];
    // refused starts excluded: they must not raise busy
    sequence start_s;
        PREADY && PWRITE && !PSLVERR && PADDR == '0 && PWDATA[0];
    endsequence
    rdy_in_access_a: assert property (PREADY |-> PSEL && PENABLE) else $error("stray ready");
    rdy_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready too long");
    err_with_rdy_a: assert property (PSLVERR |-> PREADY) else $error("lone error");
    access_two_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("slow");
    busy_refuse_a: assert property (BUSY && PREADY && PWRITE |-> PSLVERR) else $error("busy");
    one_cyc_a:
        assert property (start_s ##0 op inside {6'h00, 6'h01, 6'h09, 6'h0A, 6'h0B, 6'h26,
            6'h27, 6'h28} |=> BUSY ##1 !BUSY) else $error("one cycle op length");
    two_cyc_a:
        assert property (start_s ##0 op inside {6'h02, 6'h03, 6'h24, 6'h25}
            |=> BUSY[*2] ##1 !BUSY) else $error("two cycle op length");
    exit_four_a:
        assert property (start_s ##0 op inside {6'h06, 6'h07} |=> BUSY[*4] ##1 !BUSY)
            else $error("exit length");
endmodule

// [bsu_host.sv]
`timescale 1ns/1ps
module bsu_host (
    input  wire logic        clk, pready, pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0,
    output logic [7:0]       paddr = 8'h00,
    output logic [31:0]      pwdata = 32'h0
);
    // ready and data read at the ready edge, before the slave's own update lands
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] q, output logic e);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        {q, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
endmodule

// [branch_skip_bit_instruction_unit_tb.sv]
`timescale 1ns/1ps
module branch_skip_bit_instruction_unit_tb;
    import bsu_pkg::*;
    logic             ref_clk = 1'b0, rst_n = 1'b0, e;
    wire logic        psel, penable, pwrite, pready, pslverr, busy;
    wire logic [7:0]  paddr;
    wire logic [31:0] pwdata, prdata;
    logic [31:0]      q;
    int               n_errors = 0, n_checks = 0, cyc = 0;
    always #25 ref_clk = ~ref_clk;
    bsu_top dut_u (.REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .BUSY(busy));
    bsu_host host_u (.clk(ref_clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    task chk(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, q, e);
    endtask
    task rd(input logic [7:0] a);
        host_u.xfer(1'b0, a, 32'h0, q, e);
    endtask
    task run(input bsu_op_t op, input logic [2:0] n, input logic [7:0] a, input logic [31:0] w);
        wr(ADDR_CTRL, {18'h0, op, 8'h01});
        do @(negedge ref_clk); while (busy === 1'b1);
        rd(ADDR_STATUS);
        chk(q, {25'h0, n, 4'h0});
        rd(a);
        chk(q, w);
    endtask
    task t_flow();
        wr(ADDR_PC, 32'h0010);
        wr(ADDR_OFFSET, 32'h0FFE);
        run(OP_RELATIVE_JUMP, 3'h2, ADDR_PC, 32'h000F);
        wr(ADDR_FLAGS, 32'h04);
        wr(ADDR_OFFSET, 32'h0005);
        run(OP_BRANCH_SIGNED_LESS, 3'h2, ADDR_PC, 32'h0015);
        run(OP_BRANCH_SIGNED_GE, 3'h1, ADDR_PC, 32'h0016);
        wr(ADDR_OPND, 32'h0008_5A5A);
        run(OP_COMPARE_SKIP_EQUAL, 3'h3, ADDR_PC, 32'h0019);
    endtask
    task t_bits();
        wr(ADDR_IO, 32'h0F);
        wr(ADDR_OPND, 32'h0007_0000);
        run(OP_IO_BIT_FORCE_ONE, 3'h2, ADDR_IO, 32'h8F);
        wr(ADDR_OPND, 32'h0);
        run(OP_IO_BIT_FORCE_ZERO, 3'h2, ADDR_IO, 32'h8E);
        wr(ADDR_FLAGS, 32'h01);
        wr(ADDR_OPND, 32'h81);
        run(OP_ROTATE_LEFT_CARRY, 3'h1, ADDR_FLAGS, 32'h09);
    endtask
    task t_exit();
        wr(ADDR_FLAGS, 32'h0);
        wr(ADDR_STACK, 32'h1234);
        wr(ADDR_CTRL, {18'h0, OP_INTERRUPT_EXIT, 8'h01});
        wr(ADDR_PC, 32'h0);
        chk({31'h0, e}, 32'h1);
        rd(ADDR_PC);
        chk(q, 32'h1234);
        run(OP_SUBROUTINE_EXIT, 3'h4, ADDR_FLAGS, 32'h80);
        rd(8'h80);
        chk({q[30:0], e}, 32'h1);
    endtask
    task t_more();
        wr(ADDR_OPND, 32'h0000_2110);
        run(OP_RELATIVE_CALL, 3'h3, ADDR_STACK, 32'h1235);
        wr(ADDR_ZPTR, 32'h0040);
        run(OP_POINTER_JUMP, 3'h2, ADDR_PC, 32'h0040);
        run(OP_SKIP_REG_BIT_ONE, 3'h2, ADDR_PC, 32'h0042);
        run(OP_SKIP_REG_BIT_ZERO, 3'h1, ADDR_PC, 32'h0043);
        run(OP_COMPARE_REGS, 3'h1, ADDR_FLAGS, 32'hA5);
        run(OP_BRANCH_EQUAL, 3'h1, ADDR_PC, 32'h0045);
        run(OP_BRANCH_LOWER, 3'h2, ADDR_PC, 32'h004B);
        run(OP_ALL_ONES_REGISTER, 3'h1, ADDR_RESULT, 32'hFF);
        run(OP_ZERO_REGISTER, 3'h1, ADDR_RESULT, 32'h00);
        run(OP_SHIFT_LEFT_LOGICAL, 3'h1, ADDR_RESULT, 32'h20);
        run(OP_SHIFT_RIGHT_LOGICAL, 3'h1, ADDR_FLAGS, 32'hA0);
        run(OP_BRANCH_INTERRUPTS_ON, 3'h2, ADDR_PC, 32'h0055);
        run(OP_BRANCH_HALF_CARRY_ONE, 3'h2, ADDR_PC, 32'h005B);
    endtask
    task summarize();
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_flow();
        t_bits();
        t_exit();
        t_more();
        summarize();
    end
endmodule
bind bsu_top bsu_chk #(.ADDR_W(ADDR_W)) chk_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR), .BUSY(BUSY),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA));
